/* verilog/cmpo_top.sv */
// Digital side of the dual comparator: filter, sync, edge flags, input routes, registers
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module cmpo_top #(
	parameter int NUM_CMP = 2
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclken,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cmpo_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog side
	input wire logic [NUM_CMP-1:0] raw_result,
	input wire logic timer_src_clk,
	// Results and flags
	output logic [NUM_CMP-1:0] comparator_result_bit,
	output logic [NUM_CMP-1:0] result_pin_oe,
	output logic [NUM_CMP-1:0] comparator_irq_flag,
	output logic [NUM_CMP-1:0] comparator_on,
	// Input routes, one-hot or all zero
	output logic [NUM_CMP-1:0][4:0] noninv_node,
	output logic [NUM_CMP-1:0][4:0] inv_node
);
	// Elaboration checks on the parameters
	if (NUM_CMP != 2)
	begin : g_bad_num
		$error("cmpo_top supports exactly two comparators");
	end
	if (cmpo_pkg::HOLD_CYC >= (1 << cmpo_pkg::HOLD_W))
	begin : g_bad_hold
		$error("cmpo_top hold counter too narrow");
	end

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	logic [7:0] idx;
	logic setup;
	logic wr_acc;
	logic mapped;
	assign idx = paddr[cmpo_pkg::IDX_LSB +: 8];
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite && pclken;
	// Access completes only while the block runs
	assign pready = pclken;
	always_comb
	begin
		unique case (idx)
			cmpo_pkg::CMP2_CONTROL_0_IDX, cmpo_pkg::CMP2_CONTROL_1_IDX,
			cmpo_pkg::CMP1_CONTROL_0_IDX, cmpo_pkg::CMP1_CONTROL_1_IDX,
			cmpo_pkg::CMP_OUTPUT_MIRROR_IDX, cmpo_pkg::CMP_IRQ_FLAG_IDX: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	// Unmapped or misaligned addresses answer with an error
	assign pslverr = psel && penable && (!mapped || (paddr[1:0] != 2'h0));

	// ****************************************************************
	// Timer clock synchroniser and falling edge
	// ****************************************************************
	logic tclk_s1;
	logic tclk_s2;
	logic tclk_d;
	logic tclk_fall;
	// Two flops, then a third for the edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tclk_s1 <= 1'b0;
			tclk_s2 <= 1'b0;
			tclk_d <= 1'b0;
		end
		else if (pclken)
		begin
			tclk_s1 <= timer_src_clk;
			tclk_s2 <= tclk_s1;
			tclk_d <= tclk_s2;
		end
	end
	assign tclk_fall = tclk_d && !tclk_s2;

	// ****************************************************************
	// Per comparator logic
	// ****************************************************************
	logic [NUM_CMP-1:0][7:0] ctl0;
	logic [NUM_CMP-1:0][7:0] ctl1;
	logic [NUM_CMP-1:0] res_s1;
	logic [NUM_CMP-1:0] res_s2;
	logic [NUM_CMP-1:0] adj;
	logic [NUM_CMP-1:0] filt;
	logic [NUM_CMP-1:0] latched;
	logic [NUM_CMP-1:0] res_prev;
	logic [NUM_CMP-1:0] rise_ev;
	logic [NUM_CMP-1:0] fall_ev;
	logic [NUM_CMP-1:0][cmpo_pkg::HOLD_W-1:0] hold_cnt;
	logic [NUM_CMP-1:0] next_result;

	genvar i;
	generate
		for (i = 0; i < NUM_CMP; i++)
		begin : g_cmp
			logic [7:0] c0_idx;
			logic [7:0] c1_idx;
			assign c0_idx = (i == 0) ? cmpo_pkg::CMP1_CONTROL_0_IDX
				: cmpo_pkg::CMP2_CONTROL_0_IDX;
			assign c1_idx = (i == 0) ? cmpo_pkg::CMP1_CONTROL_1_IDX
				: cmpo_pkg::CMP2_CONTROL_1_IDX;

			// Control registers; sleep has no reset, so contents survive it
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					ctl0[i] <= cmpo_pkg::CONTROL_0_RESET;
					ctl1[i] <= cmpo_pkg::CONTROL_1_RESET;
				end
				else if (wr_acc && (paddr[1:0] == 2'h0))
				begin
					if (idx == c0_idx)
						ctl0[i] <= pwdata[7:0];
					if (idx == c1_idx)
						ctl1[i] <= pwdata[7:0];
				end
			end

			// Result synchroniser from the analog core
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					res_s1[i] <= 1'b0;
					res_s2[i] <= 1'b0;
				end
				else if (pclken)
				begin
					res_s1[i] <= raw_result[i];
					res_s2[i] <= res_s1[i];
				end
			end

			// Disabled core reads low, then the inversion applies
			assign adj[i] = (ctl0[i][cmpo_pkg::C0_ON_BIT] & res_s2[i])
				^ ctl0[i][cmpo_pkg::C0_INVERT_BIT];

			// Glitch filter: a change starts a hold that blocks reversal
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					filt[i] <= 1'b0;
					hold_cnt[i] <= '0;
				end
				else if (pclken)
				begin
					if (ctl0[i][cmpo_pkg::C0_FILTER_BIT] && (hold_cnt[i] != '0))
						hold_cnt[i] <= hold_cnt[i] - 1'b1;
					else if (adj[i] != filt[i])
					begin
						filt[i] <= adj[i];
						hold_cnt[i] <= ctl0[i][cmpo_pkg::C0_FILTER_BIT]
							? cmpo_pkg::HOLD_W'(cmpo_pkg::HOLD_CYC) : '0;
					end
				end
			end

			// Timer sync latch on the falling timer clock edge
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					latched[i] <= 1'b0;
				else if (pclken && tclk_fall)
					latched[i] <= filt[i];
			end
			assign next_result[i] = ctl0[i][cmpo_pkg::C0_SYNC_BIT] ? latched[i] : filt[i];

			// Result bit and its previous value for edges
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					comparator_result_bit[i] <= 1'b0;
					res_prev[i] <= 1'b0;
				end
				else if (pclken)
				begin
					comparator_result_bit[i] <= next_result[i];
					res_prev[i] <= comparator_result_bit[i];
				end
			end
			assign rise_ev[i] = comparator_result_bit[i] && !res_prev[i];
			assign fall_ev[i] = !comparator_result_bit[i] && res_prev[i];

			// Interrupt flag: write one clears, set wins over clear
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					comparator_irq_flag[i] <= 1'b0;
				else if (pclken)
				begin
					if ((rise_ev[i] && ctl1[i][cmpo_pkg::C1_RISE_BIT])
						|| (fall_ev[i] && ctl1[i][cmpo_pkg::C1_FALL_BIT]))
						comparator_irq_flag[i] <= 1'b1;
					else if (wr_acc && (paddr[1:0] == 2'h0)
						&& (idx == cmpo_pkg::CMP_IRQ_FLAG_IDX) && pwdata[i])
						comparator_irq_flag[i] <= 1'b0;
				end
			end

			// Input routes decoded from the select fields
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					noninv_node[i] <= 5'h00;
					inv_node[i] <= 5'h00;
					result_pin_oe[i] <= 1'b0;
					comparator_on[i] <= 1'b0;
				end
				else if (pclken)
				begin
					noninv_node[i] <= 5'h00;
					unique case (ctl1[i][cmpo_pkg::C1_PSEL_LSB +: 3])
						3'h0: noninv_node[i][cmpo_pkg::NONINV_PIN] <= 1'b1;
						3'h1: noninv_node[i][cmpo_pkg::NONINV_DAC] <= 1'b1;
						3'h2: noninv_node[i][cmpo_pkg::NONINV_FVR] <= 1'b1;
						3'h3: noninv_node[i][cmpo_pkg::NONINV_SLOPE] <= 1'b1;
						3'h4: noninv_node[i][cmpo_pkg::NONINV_AGND] <= 1'b1;
						default: noninv_node[i] <= 5'h00;
					endcase
					if (ctl1[i][cmpo_pkg::C1_NSEL_LSB + 2])
						inv_node[i] <= 5'h10;
					else
						inv_node[i] <= 5'(5'h01 << ctl1[i][cmpo_pkg::C1_NSEL_LSB +: 2]);
					result_pin_oe[i] <= ctl0[i][cmpo_pkg::C0_OE_BIT]
						& ctl0[i][cmpo_pkg::C0_ON_BIT];
					comparator_on[i] <= ctl0[i][cmpo_pkg::C0_ON_BIT];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Read data, captured in the setup cycle
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (pclken && setup && !pwrite)
		begin
			unique case (idx)
				cmpo_pkg::CMP1_CONTROL_0_IDX:
					prdata <= {24'h000000, ctl0[0][7], comparator_result_bit[0], ctl0[0][5:0]};
				cmpo_pkg::CMP2_CONTROL_0_IDX:
					prdata <= {24'h000000, ctl0[1][7], comparator_result_bit[1], ctl0[1][5:0]};
				cmpo_pkg::CMP1_CONTROL_1_IDX: prdata <= {24'h000000, ctl1[0]};
				cmpo_pkg::CMP2_CONTROL_1_IDX: prdata <= {24'h000000, ctl1[1]};
				cmpo_pkg::CMP_OUTPUT_MIRROR_IDX:
					prdata <= {30'h0, comparator_result_bit};
				cmpo_pkg::CMP_IRQ_FLAG_IDX: prdata <= {30'h0, comparator_irq_flag};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_mirror_read;
		pclken && setup && !pwrite && (idx == cmpo_pkg::CMP_OUTPUT_MIRROR_IDX);
	endsequence

	sequence s_ctl1_write(int n, logic [7:0] ci);
		wr_acc && (paddr[1:0] == 2'h0) && (idx == ci);
	endsequence

	a_mirror_layout: assert property (
		s_mirror_read |=> (prdata[31:2] == 30'h00000000)
			&& (prdata[1:0] == $past(comparator_result_bit)))
		else $error("mirror read data wrong");

	a_ctl1_write: assert property (
		s_ctl1_write(1, cmpo_pkg::CMP2_CONTROL_1_IDX) |=> (ctl1[1] == $past(pwdata[7:0])))
		else $error("control 1 write lost");

	a_sync_holds: assert property (
		pclken && ctl0[0][cmpo_pkg::C0_SYNC_BIT] && !tclk_fall && $stable(ctl0[0])
			|=> $stable(latched[0]))
		else $error("sync latch moved without timer edge");

	for (genvar k = 0; k < NUM_CMP; k++)
	begin : g_chk
		sequence s_filt_change;
			pclken && ctl0[k][cmpo_pkg::C0_FILTER_BIT] && (adj[k] != filt[k])
				&& (hold_cnt[k] == '0);
		endsequence

		a_hold_block: assert property (
			s_filt_change |=> $changed(filt[k]) ##1 $stable(filt[k]))
			else $error("filter reversed inside hold window");

		a_rise_flag: assert property (
			pclken && rise_ev[k] && ctl1[k][cmpo_pkg::C1_RISE_BIT] |=> comparator_irq_flag[k])
			else $error("rising edge did not set flag");

		a_rise_masked: assert property (
			pclken && !comparator_irq_flag[k] && rise_ev[k]
				&& !ctl1[k][cmpo_pkg::C1_RISE_BIT] |=> !comparator_irq_flag[k])
			else $error("masked rising edge set flag");

		a_fall_flag: assert property (
			pclken && fall_ev[k] && ctl1[k][cmpo_pkg::C1_FALL_BIT] |=> comparator_irq_flag[k])
			else $error("falling edge did not set flag");

		a_noninv_route: assert property (
			pclken && (ctl1[k][5:3] == 3'h2) |=> (noninv_node[k] == 5'h04))
			else $error("positive route wrong");

		a_inv_slope: assert property (
			pclken && ctl1[k][2] |=> (inv_node[k] == 5'h10))
			else $error("negative route not slope");
	end
endmodule : cmpo_top

/* verilog/cmpo_pkg.sv */
// Constants shared by the comparator output control block
package cmpo_pkg;
	// ****************************************************************
	// Register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [7:0] CMP2_CONTROL_0_IDX = 8'h9B;
	localparam logic [7:0] CMP2_CONTROL_1_IDX = 8'h9C;
	localparam logic [7:0] CMP1_CONTROL_0_IDX = 8'hA0;
	localparam logic [7:0] CMP1_CONTROL_1_IDX = 8'hA1;
	localparam logic [7:0] CMP_OUTPUT_MIRROR_IDX = 8'hA2;
	localparam logic [7:0] CMP_IRQ_FLAG_IDX = 8'hA3;
	localparam int ADDR_W = 10;
	localparam int IDX_LSB = 2;
	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] CONTROL_0_RESET = 8'h04;
	localparam logic [7:0] CONTROL_1_RESET = 8'h00;
	// ****************************************************************
	// Control register 0 field positions
	// ****************************************************************
	localparam int C0_ON_BIT = 7;
	localparam int C0_RESULT_BIT = 6;
	localparam int C0_OE_BIT = 5;
	localparam int C0_INVERT_BIT = 4;
	localparam int C0_FILTER_BIT = 3;
	localparam int C0_SYNC_BIT = 0;
	// ****************************************************************
	// Control register 1 field positions
	// ****************************************************************
	localparam int C1_RISE_BIT = 7;
	localparam int C1_FALL_BIT = 6;
	localparam int C1_PSEL_LSB = 3;
	localparam int C1_NSEL_LSB = 0;
	// ****************************************************************
	// Glitch filter hold window
	// ****************************************************************
	localparam int HOLD_NS = 20;
	localparam int CLK_PERIOD_NS = 40;
	localparam int HOLD_CYC_RAW = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (HOLD_CYC_RAW < 1) ? 1 : HOLD_CYC_RAW;
	localparam int HOLD_W = 4;
	// ****************************************************************
	// Input route one-hot positions
	// ****************************************************************
	localparam int NONINV_PIN = 0;
	localparam int NONINV_DAC = 1;
	localparam int NONINV_FVR = 2;
	localparam int NONINV_SLOPE = 3;
	localparam int NONINV_AGND = 4;
	localparam int INV_SLOPE = 4;
endpackage : cmpo_pkg

/* dv/cmpo_analog_model.sv */
// Behavioural model of the analog comparator cores and their input routes
`timescale 1ns/10ps
module cmpo_analog_model (
	// Routing and enables from the block
	input wire logic [1:0] comparator_on,
	input wire logic [1:0][4:0] noninv_node,
	input wire logic [1:0][4:0] inv_node,
	// Scenario control: which core sees its plus node above its minus node
	input wire logic [1:0] drive_high,
	// Comparator outputs
	output logic [1:0] raw_result
);
	// A core that is off, or has a node left unrouted, drives low
	always_comb
	begin
		for (int k = 0; k < 2; k++)
		begin
			raw_result[k] = comparator_on[k] & drive_high[k] & (|noninv_node[k]) & (|inv_node[k]);
		end
	end
endmodule : cmpo_analog_model

/* dv/comparator_output_control_tb_top.sv */
// Self-checking bench for the comparator output control block
`timescale 1ns/10ps
module comparator_output_control_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] raw_result;
	logic [1:0] drive_high = 2'b00;
	logic pclken = 1'b1;
	logic tclk = 1'b0;
	logic [1:0] result_pin_oe;
	logic [1:0] comparator_result_bit;
	logic [1:0] comparator_irq_flag;
	logic [1:0] comparator_on;
	logic [1:0][4:0] noninv_node;
	logic [1:0][4:0] inv_node;
	logic [31:0] rd;
	logic err;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;
	// Clock, 40 ns period
	always #20 pclk = ~pclk;
	cmpo_top cmpo_top_i (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .raw_result(raw_result), .timer_src_clk(tclk),
		.comparator_result_bit(comparator_result_bit), .result_pin_oe(result_pin_oe),
		.comparator_irq_flag(comparator_irq_flag), .comparator_on(comparator_on),
		.noninv_node(noninv_node), .inv_node(inv_node));
	cmpo_analog_model cmpo_analog_model_i (.comparator_on(comparator_on),
		.noninv_node(noninv_node), .inv_node(inv_node), .drive_high(drive_high),
		.raw_result(raw_result));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd, {24'h00_0000, exp});
	endtask : rd_chk
	// Wait for a filtered result level, then let the flag settle
	task automatic wait_res(input int k, input logic v);
		for (int i = 0; i < 20 && comparator_result_bit[k] !== v; i++)
			@(posedge pclk);
		chk({31'h0, comparator_result_bit[k]}, {31'h0, v});
		repeat (2) @(posedge pclk);
		#1;
	endtask : wait_res
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic test_reset_values;
		rd_chk(cmpo_pkg::CMP2_CONTROL_0_IDX, 8'h04);
		rd_chk(cmpo_pkg::CMP2_CONTROL_1_IDX, 8'h00);
		rd_chk(cmpo_pkg::CMP1_CONTROL_1_IDX, 8'h00);
		rd_chk(cmpo_pkg::CMP_OUTPUT_MIRROR_IDX, 8'h00);
	endtask : test_reset_values
	task automatic test_rw_refuse;
		apb(1'b1, cmpo_pkg::CMP1_CONTROL_1_IDX, 8'hFF);
		rd_chk(cmpo_pkg::CMP1_CONTROL_1_IDX, 8'hFF);
		apb(1'b1, cmpo_pkg::CMP_OUTPUT_MIRROR_IDX, 8'hFF);
		rd_chk(cmpo_pkg::CMP_OUTPUT_MIRROR_IDX, 8'h00);
		apb(1'b0, 8'h00, 8'h00);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, cmpo_pkg::CMP1_CONTROL_1_IDX, 8'h00);
	endtask : test_rw_refuse
	task automatic test_routes;
		for (int c = 0; c < 8; c++)
		begin
			apb(1'b1, cmpo_pkg::CMP2_CONTROL_1_IDX, {2'b00, c[2:0], c[2:0]});
			repeat (2) @(posedge pclk);
			#1;
			chk({27'h0, noninv_node[1]}, (c < 5) ? (32'h1 << c) : 32'h0);
			chk({27'h0, inv_node[1]}, (c < 4) ? (32'h1 << c) : 32'h10);
		end
	endtask : test_routes
	task automatic test_edges;
		apb(1'b1, cmpo_pkg::CMP1_CONTROL_1_IDX, 8'h80);
		apb(1'b1, cmpo_pkg::CMP1_CONTROL_0_IDX, 8'hA0);
		drive_high <= 2'b01;
		wait_res(0, 1'b1);
		chk({30'h0, comparator_irq_flag}, 32'h1);
		chk({30'h0, result_pin_oe}, 32'h1);
		chk({30'h0, comparator_on}, 32'h1);
		rd_chk(cmpo_pkg::CMP_OUTPUT_MIRROR_IDX, 8'h01);
		apb(1'b1, cmpo_pkg::CMP_IRQ_FLAG_IDX, 8'h01);
		drive_high <= 2'b00;
		wait_res(0, 1'b0);
		chk({30'h0, comparator_irq_flag}, 32'h0);
		apb(1'b1, cmpo_pkg::CMP1_CONTROL_1_IDX, 8'h40);
		drive_high <= 2'b01;
		wait_res(0, 1'b1);
		chk({30'h0, comparator_irq_flag}, 32'h0);
		drive_high <= 2'b00;
		wait_res(0, 1'b0);
		chk({30'h0, comparator_irq_flag}, 32'h1);
		apb(1'b1, cmpo_pkg::CMP_IRQ_FLAG_IDX, 8'h01);
	endtask : test_edges
	// Inverting a switched-off core still produces a flagged edge
	task automatic test_invert_flag;
		apb(1'b1, cmpo_pkg::CMP2_CONTROL_1_IDX, 8'h80);
		apb(1'b1, cmpo_pkg::CMP2_CONTROL_0_IDX, 8'h14);
		wait_res(1, 1'b1);
		chk({30'h0, comparator_irq_flag}, 32'h2);
		rd_chk(cmpo_pkg::CMP_OUTPUT_MIRROR_IDX, 8'h02);
		// Drop the result, then let the clear land on the edge that sets the flag
		apb(1'b1, cmpo_pkg::CMP2_CONTROL_0_IDX, 8'h04);
		wait_res(1, 1'b0);
		apb(1'b1, cmpo_pkg::CMP2_CONTROL_0_IDX, 8'h14);
		apb(1'b1, cmpo_pkg::CMP_IRQ_FLAG_IDX, 8'h02);
		#1;
		chk({30'h0, comparator_irq_flag}, 32'h2);
	endtask : test_invert_flag
	// A frozen block holds pready low; the master waits and the write lands later
	task automatic test_clock_enable;
		@(posedge pclk);
		pclken <= 1'b0;
		fork
			apb(1'b1, cmpo_pkg::CMP1_CONTROL_1_IDX, 8'h3F);
			begin
				repeat (4) @(posedge pclk);
				chk({31'h0, pready}, 32'h0);
				pclken <= 1'b1;
			end
		join
		rd_chk(cmpo_pkg::CMP1_CONTROL_1_IDX, 8'h3F);
		apb(1'b1, cmpo_pkg::CMP1_CONTROL_1_IDX, 8'h00);
	endtask : test_clock_enable
	// Sync mode shows the result only after a falling timer clock edge
	task automatic test_sync;
		@(posedge pclk);
		tclk <= 1'b1;
		apb(1'b1, cmpo_pkg::CMP1_CONTROL_0_IDX, 8'h81);
		drive_high <= 2'b01;
		repeat (10) @(posedge pclk);
		chk({31'h0, comparator_result_bit[0]}, 32'h0);
		tclk <= 1'b0;
		wait_res(0, 1'b1);
	endtask : test_sync
	// Width in cycles of the result after a one-cycle raw pulse on comparator one
	task automatic pulse_width(output int n);
		n = 0;
		@(posedge pclk);
		drive_high <= 2'b01;
		@(posedge pclk);
		drive_high <= 2'b00;
		repeat (12)
		begin
			@(posedge pclk);
			if (comparator_result_bit[0] === 1'b1)
				n++;
		end
	endtask : pulse_width
	// The hold window keeps a new level for the hold count before it may reverse
	task automatic test_filter;
		int w;
		apb(1'b1, cmpo_pkg::CMP1_CONTROL_0_IDX, 8'h80);
		drive_high <= 2'b00;
		wait_res(0, 1'b0);
		pulse_width(w);
		chk(w, 32'h1);
		apb(1'b1, cmpo_pkg::CMP1_CONTROL_0_IDX, 8'h88);
		pulse_width(w);
		chk(w, cmpo_pkg::HOLD_CYC + 1);
	endtask : test_filter
	// A reset in mid-run brings both control 1 registers and comparator two's control 0 back to their reset values
	task automatic test_midrun_reset;
		apb(1'b1, cmpo_pkg::CMP2_CONTROL_1_IDX, 8'h5A);
		apb(1'b1, cmpo_pkg::CMP1_CONTROL_1_IDX, 8'hC3);
		rd_chk(cmpo_pkg::CMP2_CONTROL_1_IDX, 8'h5A);
		@(posedge pclk);
		presetn <= 1'b0;
		drive_high <= 2'b00;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		test_reset_values();
		chk({27'h0, noninv_node[0]}, 32'h1);
		chk({27'h0, inv_node[0]}, 32'h1);
	endtask : test_midrun_reset
	// ****************************************************************
	// Timeout and main sequence
	// ****************************************************************
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_mismatch++;
			$display("[FAIL] %0t run did not complete", $time);
			print_verdict();
		end
	end
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		test_reset_values();
		test_rw_refuse();
		test_clock_enable();
		test_routes();
		test_edges();
		test_invert_flag();
		test_sync();
		test_filter();
		test_midrun_reset();
		print_verdict();
	end
endmodule : comparator_output_control_tb_top
